// ===== sfrs_pkg.sv
// Package of constants and types shared by both ends of the flash rescue link
// Behaviour
// - Host sends both rescue parts in order
// - Burst one: seven clocks, line zero high
// - Burst two: thirteen clocks, line zero high
// - Burst three: twenty-five clocks ends place mode
// - Rescued device stays single-line until power-up
// - Part two: eight clocks, lines zero, three high
// - Part two forces single-line command decoding
// - Host then requests a nonvolatile configuration rewrite
// - Delivered array bytes read all ones
// - Delivered status register reads zero
// - Place mode: three address bytes, no instruction
// - First dummy bit zero keeps, one exits
package sfrs_pkg;
    localparam int          BURST1_CLKS     = 7;
    localparam int          BURST2_CLKS     = 13;
    localparam int          BURST3_CLKS     = 25;
    localparam int          PART2_CLKS      = 8;
    localparam int          XIP_ADDR_BYTES  = 3;
    localparam int          CLK_HZ          = 50_000_000;
    localparam int          MIN_DESELECT_NS = 50;
    localparam int          MIN_DESELECT_CYC =
        (MIN_DESELECT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [7:0]  ERASED_BYTE     = 8'hFF;
    localparam logic [7:0]  STATUS_RESET    = 8'h00;
    localparam logic [7:0]  WRITE_NONVOLATILE_CONFIG_CMD = 8'hB1;
    localparam int          SCK_HALF_DIV    = 4;

    typedef enum logic [1:0] {
        SFRS_PROTO_SINGLE,
        SFRS_PROTO_DUAL,
        SFRS_PROTO_QUAD
    } sfrs_proto_type;
endpackage : sfrs_pkg

// ===== sfrs_if.sv
// Serial link between rescue host and flash device
`timescale 1ns/10ps
interface sfrs_if;
    logic sel_n;
    logic sck;
    logic serial_data_line_zero;
    logic data_line_three_hold;
    modport host (
        output sel_n,
        output sck,
        output serial_data_line_zero,
        output data_line_three_hold
    );
    modport device (
        input  sel_n,
        input  sck,
        input  serial_data_line_zero,
        input  data_line_three_hold
    );
endinterface : sfrs_if

// ===== sfrs_device.sv
// Flash device end: recognises rescue bursts, holds protocol and place-mode state
`timescale 1ns/10ps
module sfrs_device
    import sfrs_pkg::*;
(
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_n,
    sfrs_if.device                     link,
    input  wire logic                  i_nv_xip,
    input  wire sfrs_pkg::sfrs_proto_type i_nv_proto,
    output logic                       o_xip,
    output sfrs_pkg::sfrs_proto_type   o_proto,
    output logic                       o_locked,
    output logic [7:0]                 o_status,
    output logic [7:0]                 o_array_byte,
    output logic [23:0]                o_xip_addr,
    output logic                       o_xip_addr_valid
);
    import sfrs_pkg::*;

    logic [1:0] sel_sync, sck_sync, d0_sync, d3_sync;
    logic       sck_prev, sel_prev;
    logic [5:0] clk_cnt;
    logic       d0_all, d3_all;
    logic [1:0] rescue_step;
    logic       strap_taken;
    logic [23:0] addr_sr;
    logic       confirm_seen;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sel_sync <= 2'h3;
            sck_sync <= 2'h0;
            d0_sync  <= 2'h0;
            d3_sync  <= 2'h0;
        end else begin
            sel_sync <= {sel_sync[0], link.sel_n};
            sck_sync <= {sck_sync[0], link.sck};
            d0_sync  <= {d0_sync[0], link.serial_data_line_zero};
            d3_sync  <= {d3_sync[0], link.data_line_three_hold};
        end
    end

    wire sel_n    = sel_sync[1];
    wire sck_rise = sck_sync[1] && !sck_prev && !sel_n;
    wire sel_rise = sel_n && !sel_prev;
    wire sel_fall = !sel_n && sel_prev;
    wire d0       = d0_sync[1];
    wire d3       = d3_sync[1];

    // Judged only at deselect so a burst overrunning its count never qualifies
    wire hit1 = sel_rise && d0_all && clk_cnt == 6'(BURST1_CLKS);
    wire hit2 = sel_rise && d0_all && clk_cnt == 6'(BURST2_CLKS);
    wire hit3 = sel_rise && d0_all && clk_cnt == 6'(BURST3_CLKS);
    wire hit_p2 = sel_rise && d0_all && d3_all && clk_cnt == 6'(PART2_CLKS);
    wire addr_done = o_xip && clk_cnt == 6'(XIP_ADDR_BYTES * 8);
    wire confirm_bit = sck_rise && o_xip && clk_cnt == 6'(XIP_ADDR_BYTES * 8)
                       && !confirm_seen;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sck_prev <= 1'b0;
            sel_prev <= 1'b1;
            clk_cnt  <= 6'h00;
            d0_all   <= 1'b1;
            d3_all   <= 1'b1;
        end else begin
            sck_prev <= sck_sync[1];
            sel_prev <= sel_n;
            if (sel_fall) begin
                clk_cnt <= 6'h00;
                d0_all  <= 1'b1;
                d3_all  <= 1'b1;
            end else if (sck_rise) begin
                if (clk_cnt != 6'h3F)
                    clk_cnt <= clk_cnt + 6'h01;
                d0_all <= d0_all & d0;
                d3_all <= d3_all & d3;
            end
        end
    end

    // Rescue step tracker; any other selection restarts part one; step 3 holds except a seven-clock burst returns it to step 1
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rescue_step <= 2'h0;
        end else if (sel_rise) begin
            if (rescue_step == 2'h0 && hit1)
                rescue_step <= 2'h1;
            else if (rescue_step == 2'h1 && hit2)
                rescue_step <= 2'h2;
            else if (rescue_step == 2'h2 && hit3)
                rescue_step <= 2'h3;
            else if (rescue_step == 2'h3 && hit_p2)
                rescue_step <= 2'h3;
            else if (hit1)
                rescue_step <= 2'h1;
            else
                rescue_step <= (rescue_step == 2'h3) ? 2'h3 : 2'h0;
        end
    end

    // Nonvolatile straps are caught on the first clock after reset release
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            strap_taken <= 1'b0;
            o_xip       <= 1'b0;
            o_proto     <= SFRS_PROTO_SINGLE;
            o_locked    <= 1'b0;
        end else if (!strap_taken) begin
            strap_taken <= 1'b1;
            o_xip       <= i_nv_xip;
            o_proto     <= i_nv_proto;
        end else begin
            if (rescue_step == 2'h2 && hit3) begin
                o_xip    <= 1'b0;
                o_locked <= 1'b1;
            end else if (confirm_bit && d0 && !o_locked) begin
                o_xip    <= 1'b0;
            end
            if (hit_p2)
                o_proto <= SFRS_PROTO_SINGLE;
            if (o_locked) begin
                o_xip   <= 1'b0;
                o_proto <= SFRS_PROTO_SINGLE;
            end
        end
    end

    // Place-mode address capture: first three bytes, no instruction byte
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            addr_sr          <= 24'h000000;
            o_xip_addr       <= 24'h000000;
            o_xip_addr_valid <= 1'b0;
            confirm_seen     <= 1'b0;
        end else begin
            o_xip_addr_valid <= 1'b0;
            if (sel_fall)
                confirm_seen <= 1'b0;
            if (sck_rise && o_xip && clk_cnt < 6'(XIP_ADDR_BYTES * 8))
                addr_sr <= {addr_sr[22:0], d0};
            if (confirm_bit) begin
                confirm_seen     <= 1'b1;
                o_xip_addr       <= addr_sr;
                o_xip_addr_valid <= !d0 && addr_done;
            end
        end
    end

    // Delivery state: erased array, cleared status
    assign o_array_byte = ERASED_BYTE;
    assign o_status     = STATUS_RESET;
endmodule : sfrs_device

// ===== sfrs_host.sv
// Host end: generates the rescue bursts with divided serial clock
`timescale 1ns/10ps
module sfrs_host
    import sfrs_pkg::*;
(
    input  wire logic  i_clk,
    input  wire logic  i_rst_n,
    input  wire logic  i_start,
    output logic       o_busy,
    output logic       o_done,
    output logic       o_rewrite_nv_req,
    sfrs_if.host       link
);
    import sfrs_pkg::*;

    typedef enum logic [2:0] {
        SFRS_IDLE,
        SFRS_LOW,
        SFRS_HIGH,
        SFRS_GAP
    } sfrs_hstate_type;

    sfrs_hstate_type state;
    logic [2:0] burst;
    logic [5:0] edges;
    logic [3:0] div;
    logic [5:0] gap;
    logic       sck;

    function automatic logic [5:0] burst_len(input logic [2:0] b);
        unique case (b)
            3'h0:    burst_len = 6'(BURST1_CLKS);
            3'h1:    burst_len = 6'(BURST2_CLKS);
            3'h2:    burst_len = 6'(BURST3_CLKS);
            default: burst_len = 6'(PART2_CLKS);
        endcase
    endfunction : burst_len

    wire tick     = div == 4'(SCK_HALF_DIV - 1);
    wire last_rise = edges == burst_len(burst);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= SFRS_IDLE;
            burst <= 3'h0;
            edges <= 6'h00;
            div   <= 4'h0;
            gap   <= 6'h00;
            sck   <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            div <= (state == SFRS_IDLE || tick) ? 4'h0 : div + 4'h1;
            unique case (state)
                SFRS_IDLE: if (i_start) begin
                    burst <= 3'h0;
                    edges <= 6'h00;
                    state <= SFRS_LOW;
                end
                SFRS_LOW: if (tick) begin
                    if (last_rise) begin
                        state <= SFRS_GAP;
                        gap   <= 6'h00;
                    end else begin
                        sck   <= 1'b1;
                        edges <= edges + 6'h01;
                        state <= SFRS_HIGH;
                    end
                end
                SFRS_HIGH: if (tick) begin
                    sck   <= 1'b0;
                    state <= SFRS_LOW;
                end
                SFRS_GAP: begin
                    // Gap padded well past the minimum so the device sync sees it
                    if (gap == 6'(MIN_DESELECT_CYC * 4)) begin
                        edges <= 6'h00;
                        if (burst == 3'h3) begin
                            state  <= SFRS_IDLE;
                            o_done <= 1'b1;
                        end else begin
                            burst <= burst + 3'h1;
                            state <= SFRS_LOW;
                        end
                    end else begin
                        gap <= gap + 6'h01;
                    end
                end
                default: state <= SFRS_IDLE;
            endcase
        end
    end

    assign o_busy   = state != SFRS_IDLE;
    assign link.sel_n = !(state == SFRS_LOW || state == SFRS_HIGH);
    assign link.sck = sck;
    assign link.serial_data_line_zero = 1'b1;
    assign link.data_line_three_hold  = (burst == 3'h3);
    assign o_rewrite_nv_req = o_done;
endmodule : sfrs_host

// ===== sfrs_properties.sv
// Checker of the rescue link between host end and device end
`timescale 1ns/10ps
module sfrs_properties
    import sfrs_pkg::*;
(
    input  wire logic                     i_clk,
    input  wire logic                     i_rst_n,
    input  wire logic                     sel_n,
    input  wire logic                     sck,
    input  wire logic                     serial_data_line_zero,
    input  wire logic                     data_line_three_hold,
    input  wire logic                     o_locked,
    input  wire logic                     o_xip,
    input  wire sfrs_pkg::sfrs_proto_type o_proto,
    input  wire logic [7:0]               o_status,
    input  wire logic [7:0]               o_array_byte
);
    ////////////////////////////////////////
    // Rises per selection and index of the burst in the sequence
    logic [4:0] n_rise;
    logic [1:0] step;
    logic [4:0] want;
    assign want = (step == 2'h0) ? 5'(BURST1_CLKS) : (step == 2'h1) ? 5'(BURST2_CLKS) :
                  (step == 2'h2) ? 5'(BURST3_CLKS) : 5'(PART2_CLKS);
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            n_rise <= 5'h00;
            step   <= 2'h0;
        end else begin
            n_rise <= sel_n ? 5'h00 : n_rise + {4'h0, $rose(sck)};
            step   <= step + {1'b0, $rose(sel_n)};
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence burst_end_s;
        $rose(sel_n);
    endsequence
    // Four samples so a short gap cannot slip between edges
    sequence gap_s;
        sel_n [*4];
    endsequence
    burst_count_a: assert property (burst_end_s |-> n_rise == want)
        else $error("burst clock count wrong");
    line_zero_a: assert property (!sel_n && $rose(sck) |-> serial_data_line_zero)
        else $error("line zero low at a burst clock");
    line_three_a: assert property (!sel_n && $rose(sck) && step == 2'h3 |->
        data_line_three_hold)
        else $error("line three low in part two");
    deselect_gap_a: assert property (burst_end_s |-> gap_s)
        else $error("deselect gap too short");
    idle_clock_a: assert property (sel_n && $past(sel_n) |-> !$rose(sck))
        else $error("serial clock edge while deselected");
    rescue_lock_a: assert property (burst_end_s ##0 (step == 2'h2) |-> ##[1:8] o_locked)
        else $error("no lock after part one");
    lock_single_a: assert property (o_locked |-> !o_xip && o_proto == SFRS_PROTO_SINGLE)
        else $error("locked device not single line");
    lock_holds_a: assert property (!$fell(o_locked))
        else $error("lock dropped before reset");
    part_two_a: assert property (burst_end_s ##0 (step == 2'h3) |->
        ##[1:8] (o_proto == SFRS_PROTO_SINGLE))
        else $error("part two left multi line protocol");
    delivery_a: assert property (o_status == STATUS_RESET &&
        o_array_byte == ERASED_BYTE)
        else $error("delivery state wrong");
endmodule : sfrs_properties

// ===== serial_flash_rescue_sequence_tb_top.sv
// Bench: host rescues device 0, a bench driver probes device 1
`timescale 1ns/10ps
module serial_flash_rescue_sequence_tb_top;
    import sfrs_pkg::*;
    logic           i_clk;
    logic           i_rst_n;
    logic           start;
    logic           busy;
    logic           done;
    logic           rewrite;
    logic           nv_xip [2];
    sfrs_proto_type nv_proto [2];
    logic           lock [2];
    logic           execute_in_place_mode [2];
    sfrs_proto_type proto [2];
    logic [7:0]     stat [2];
    logic [7:0]     arr [2];
    logic [23:0]    xaddr [2];
    logic           xval [2];
    logic           xval_seen = 1'b0;
    logic [23:0]    a;
    logic [4:0]     q [$];
    logic [4:0]     e;
    logic [31:0]    seed = 32'hDED435CA;
    int             n_errors = 0;
    int             n_compared = 0;
    ////////////////////////////////////////
    sfrs_if lk[2] ();
    sfrs_host i_sfrs_host (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_start(start), .o_busy(busy),
        .o_done(done), .o_rewrite_nv_req(rewrite), .link(lk[0]));
    for (genvar g = 0; g < 2; g++) begin : g_dev
        sfrs_device i_sfrs_device (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(lk[g]),
            .i_nv_xip(nv_xip[g]), .i_nv_proto(nv_proto[g]), .o_xip(execute_in_place_mode[g]),
            .o_proto(proto[g]), .o_locked(lock[g]), .o_status(stat[g]),
            .o_array_byte(arr[g]), .o_xip_addr(xaddr[g]), .o_xip_addr_valid(xval[g]));
    end
    sfrs_properties i_sfrs_properties (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .sel_n(lk[0].sel_n), .sck(lk[0].sck), .serial_data_line_zero(lk[0].serial_data_line_zero),
        .data_line_three_hold(lk[0].data_line_three_hold), .o_locked(lock[0]), .o_xip(execute_in_place_mode[0]),
        .o_proto(proto[0]), .o_status(stat[0]), .o_array_byte(arr[0]));
    ////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic report_and_stop();
        if (n_errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic note(input logic d, input logic l, input logic x, input sfrs_proto_type p);
        q.push_back({d, l, x, p});
    endtask : note
    // Bench burst on link 1; released data lines show the inverse level
    task automatic burst(input int n, input logic d0, input logic d3);
        lk[1].sel_n = 1'b0;
        lk[1].serial_data_line_zero = d0;
        lk[1].data_line_three_hold = d3;
        repeat (n) begin
            repeat (4) @(negedge i_clk);
            lk[1].sck = 1'b1;
            repeat (4) @(negedge i_clk);
            lk[1].sck = 1'b0;
        end
        repeat (4) @(negedge i_clk);
        lk[1].sel_n = 1'b1;
        lk[1].serial_data_line_zero = ~d0;
        lk[1].data_line_three_hold = ~d3;
        repeat (16) @(negedge i_clk);
    endtask : burst
    // Place-mode read on link 1: address MSB first, then a zero confirmation bit
    task automatic send_addr(input logic [23:0] ad);
        lk[1].sel_n = 1'b0;
        for (int k = 0; k < 25; k++) begin
            lk[1].serial_data_line_zero = (k < 24) ? ad[23 - k] : 1'b0;
            repeat (4) @(negedge i_clk);
            lk[1].sck = 1'b1;
            repeat (4) @(negedge i_clk);
            lk[1].sck = 1'b0;
        end
        repeat (4) @(negedge i_clk);
        lk[1].sel_n = 1'b1;
        lk[1].serial_data_line_zero = 1'b1;
        repeat (16) @(negedge i_clk);
    endtask : send_addr
    always @(posedge i_clk) begin
        if (xval[1] === 1'b1)
            xval_seen <= 1'b1;
    end
    ////////////////////////////////////////
    // Device evaluates a few clocks after deselect, so wait eight
    always @(posedge lk[0].sel_n or posedge lk[1].sel_n) begin
        if (i_rst_n === 1'b1 && q.size() > 0) begin
            repeat (8) @(negedge i_clk);
            e = q.pop_front();
            chk({4'h0, lock[e[4]], execute_in_place_mode[e[4]], proto[e[4]]}, {4'h0, e[3:0]});
        end
    end
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    initial begin
        #200us;
        n_errors++;
        report_and_stop();
    end
    initial begin
        start = 1'b0;
        lk[1].sel_n = 1'b1;
        lk[1].sck = 1'b0;
        lk[1].serial_data_line_zero = 1'b0;
        lk[1].data_line_three_hold = 1'b0;
        nv_xip[1] = 1'b1;
        nv_proto[1] = SFRS_PROTO_QUAD;
        for (int r = 0; r < 2; r++) begin
            seed = lfsr(seed);
            nv_xip[0] = seed[0];
            nv_proto[0] = sfrs_proto_type'(seed[9:8] % 2'h3);
            i_rst_n = 1'b0;
            repeat (6) @(negedge i_clk);
            i_rst_n = 1'b1;
            repeat (3) @(negedge i_clk);
            chk({4'h0, lock[0], execute_in_place_mode[0], proto[0]}, {5'h00, nv_xip[0], nv_proto[0]});
            chk(stat[0], STATUS_RESET);
            chk(arr[0], ERASED_BYTE);
            for (int b = 0; b < 4; b++) begin
                note(1'b0, b > 1, (b < 2) && nv_xip[0], (b < 2) ? nv_proto[0] : SFRS_PROTO_SINGLE);
            end
            start = 1'b1;
            @(negedge i_clk);
            start = 1'b0;
            repeat (2) @(negedge i_clk);
            start = 1'b1;
            @(negedge i_clk);
            start = 1'b0;
            repeat (800) begin
                @(negedge i_clk);
                if (done === 1'b1) break;
            end
            chk({7'h00, rewrite}, 8'h01);
            repeat (30) @(negedge i_clk);
            chk({7'h00, busy}, 8'h00);
        end
        // Address read with confirmation zero keeps place mode on device 1
        seed = lfsr(seed);
        a = seed[23:0];
        note(1'b1, 1'b0, 1'b1, SFRS_PROTO_QUAD);
        send_addr(a);
        chk(xaddr[1][23:16], a[23:16]);
        chk(xaddr[1][15:8], a[15:8]);
        chk(xaddr[1][7:0], a[7:0]);
        chk({7'h00, xval_seen}, 8'h01);
        // Part two first, a low data burst, a short third burst, then a clean part one
        for (int i = 0; i < 8; i++) begin
            note(1'b1, i == 7, i != 7, SFRS_PROTO_SINGLE);
            burst((i == 0) ? 8 : (i == 4) ? 24 : (i == 3 || i == 6) ? 13 : (i == 7) ? 25 : 7,
                i != 1, i == 0);
        end
        report_and_stop();
    end
endmodule : serial_flash_rescue_sequence_tb_top
